// [rtl/cpo_pkg.sv]
package cpo_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] DISCHARGE_LIMIT2_AND_STATUS_ADDR = 8'h3c;
	localparam logic [7:0] UNDERVOLTAGE_DITHER_BUS_PROTECT_ADDR = 8'h3d;
	localparam logic [7:0] SYSTEM_THRESHOLD2_ROLE_SWAP_ADDR = 8'h3e;

	localparam logic [7:0] DISCHARGE_LIMIT2_AND_STATUS_RST = 8'h48;
	localparam logic [7:0] UNDERVOLTAGE_DITHER_BUS_PROTECT_RST = 8'h00;
	localparam logic [7:0] SYSTEM_THRESHOLD2_ROLE_SWAP_RST = 8'h24;

	// host-writable bits of each register; the rest are status
	localparam logic [7:0] DL2_WR_MASK = 8'hfc;
	localparam logic [7:0] UVB_WR_MASK = 8'hfe;
	localparam logic [7:0] ST2_WR_MASK = 8'hff;

	// field positions
	localparam int FILTER_TIME_LSB = 6;
	localparam int RATIO_LSB = 3;
	localparam int DL2_ALERT_BIT = 2;
	localparam int DL2_TRIPPED_BIT = 1;
	localparam int PASS_THROUGH_BIT = 0;
	localparam int UV_LEVEL_LSB = 5;
	localparam int DITHER_LSB = 3;
	localparam int UV_RETRY_DIS_BIT = 2;
	localparam int BUS_ALERT_BIT = 1;
	localparam int BUS_TRIPPED_BIT = 0;
	localparam int LEVEL_TWO_LSB = 2;
	localparam int TRACKS_BIT = 1;
	localparam int ROLE_SWAP_BIT = 0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int US_PER_S = 1_000_000;
	localparam int TICK_CYCLES = CLK_HZ / US_PER_S;
	localparam int FILTER_00_US = 98;
	localparam int FILTER_01_US = 1550;
	localparam int FILTER_10_US = 6250;
	localparam int FILTER_11_US = 12500;
	localparam int RETRY_WINDOW_US = 90_000_000;
	localparam int RETRY_OFF_US = 1000;
	localparam logic [2:0] RETRY_LIMIT = 3'h7;

	// serial bus target address (value is arbitrary)
	localparam logic [6:0] TARGET_ADDR = 7'h2a;

endpackage

// [rtl/cpo_filter_if.sv]
`timescale 1ns/1ps
interface cpo_filter_if;
	logic tick;
	logic over;
	logic [1:0] filter_time;
	logic tripped;

	modport regs (output tick, output over, output filter_time, input tripped);
	modport filt (input tick, input over, input filter_time, output tripped);
endinterface

// [rtl/cpo_filter.sv]
`timescale 1ns/1ps
module cpo_filter #(
	parameter int T00_US = cpo_pkg::FILTER_00_US,
	parameter int T01_US = cpo_pkg::FILTER_01_US,
	parameter int T10_US = cpo_pkg::FILTER_10_US,
	parameter int T11_US = cpo_pkg::FILTER_11_US
) (
	input wire logic clk_in, // system clock
	input wire logic rst_in, // async reset, active high
	cpo_filter_if.filt f // tick, level and trip pulse
);
	logic [13:0] cnt_q;
	logic [13:0] limit;

	function automatic logic [13:0] sel_limit(input logic [1:0] code);
		unique case (code)
			2'h0: sel_limit = 14'(T00_US);
			2'h1: sel_limit = 14'(T01_US);
			2'h2: sel_limit = 14'(T10_US);
			default: sel_limit = 14'(T11_US);
		endcase
	endfunction

	assign limit = sel_limit(f.filter_time);

	// any dip below threshold restarts the filter; trips once per excursion
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= 14'h0000;
		end else if (!f.over) begin
			cnt_q <= 14'h0000;
		end else if (f.tick && cnt_q <= limit) begin
			cnt_q <= cnt_q + 14'h0001;
		end
	end

	assign f.tripped = f.tick && f.over && (cnt_q == limit); // RULE16 RULE1
endmodule

// [rtl/cpo_regs.sv]
`timescale 1ns/1ps
// What this block does
// RULE1 - bits 7:6 of 3Ch pick trip filter 98us/1.55ms/6.25ms/12.5ms, reset 01
// RULE2 - bits 5:3 of 3Ch pick limit two as 125..400 percent of limit one
// RULE3 - bit 2 of 3Ch enables the alert profile for limit two, reset 0
// RULE4 - bit 1 of 3Ch latches a limit-two trip until host reads it
// RULE5 - bit 0 of 3Ch shows pass-through operation live, reset 0
// RULE6 - bits 7:5 of 3Dh pick undervoltage level 2.4V to 8.0V, 0.8V steps
// RULE7 - undervoltage trip starts retry; seven failures within 90s latch converter off
// RULE8 - bit 2 of 3Dh set disables undervoltage retry, reset 0
// RULE9 - bits 4:3 of 3Dh select dither off, 1x, 2x or 3x, reset 00
// RULE10 - bit 1 of 3Dh enables bus protect alert; bit 0 reports its trip
// RULE11 - bits 7:2 of 3Eh set level two: 5000mV plus 100mV per code
// RULE12 - bit 1 of 3Eh makes level two track level one, ignoring field
// RULE13 - bit 0 of 3Eh enables fast role swap, reset 0
// RULE14 - 3Ch resets to 48h; register reset restores every field
// RULE15 - 3Dh resets to 00h and 3Eh to 24h
// RULE16 - limit-two trip sets only after current stays above limit past filter time
// RULE17 - host writes to status bit positions are ignored
module cpo_regs #(
	parameter int CUR_W = 12,
	parameter int T10_US = cpo_pkg::FILTER_10_US,
	parameter int T11_US = cpo_pkg::FILTER_11_US,
	parameter int RETRY_WINDOW_US = cpo_pkg::RETRY_WINDOW_US,
	parameter int RETRY_OFF_US = cpo_pkg::RETRY_OFF_US
) (
	input wire logic CLK_IN, // 50 MHz clock
	input wire logic RST_IN, // async reset, active high
	input wire logic REG_RESET_IN, // register reset command pulse
	input wire logic SCL_IN, // serial clock from host
	input wire logic SDA_IN, // serial data level
	output logic SDA_OUT, // serial data drive value, always low
	output logic SDA_OE_N_OUT, // low while pulling data low
	input wire logic [CUR_W-1:0] DISCHARGE_CURRENT_IN, // battery discharge current
	input wire logic [CUR_W-1:0] DISCHARGE_LIMIT1_LEVEL_IN, // limit one level
	input wire logic PASS_THROUGH_OPERATION_IN, // pass-through active
	input wire logic BUS_PROTECT_TRIPPED_IN, // bus protection triggered
	input wire logic UNDERVOLTAGE_TRIP_IN, // system undervoltage event pulse
	output logic [1:0] DITHER_OUT, // dither scale code
	output logic [2:0] SYSTEM_UNDERVOLTAGE_LEVEL_OUT, // undervoltage level code
	output logic BUS_PROTECT_ALERT_ENABLE_OUT, // bus protect alert profile
	output logic DISCHARGE_LIMIT2_ALERT_OUT, // limit-two alert enabled and tripped
	output logic [5:0] SYSTEM_TRIGGER_LEVEL_TWO_OUT, // level two code
	output logic LEVEL_TWO_TRACKS_LEVEL_ONE_OUT, // use internal tracking level
	output logic ROLE_SWAP_ENABLE_OUT, // fast role swap enable
	output logic CONVERTER_ENABLE_OUT, // converter allowed to run
	output logic CONVERTER_LATCHED_OFF_OUT // converter latched off
);
	// ----------------------------------------------------------------
	// microsecond tick
	// ----------------------------------------------------------------
	logic [5:0] div_q;
	logic tick;

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			div_q <= 6'h00;
		end else begin
			div_q <= tick ? 6'h00 : div_q + 6'h01;
		end
	end

	assign tick = (div_q == 6'(cpo_pkg::TICK_CYCLES - 1));

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [7:0] dl2_q;
	logic [7:0] uvb_q;
	logic [7:0] st2_q;
	logic dl2_tripped_q;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic rd_clr;
	logic dl2_trip;
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
			input logic [7:0] mask);
		merge = (nw & mask) | (old & ~mask);
	endfunction

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			dl2_q <= cpo_pkg::DISCHARGE_LIMIT2_AND_STATUS_RST; // RULE14
			uvb_q <= cpo_pkg::UNDERVOLTAGE_DITHER_BUS_PROTECT_RST; // RULE15
			st2_q <= cpo_pkg::SYSTEM_THRESHOLD2_ROLE_SWAP_RST; // RULE15
		end else if (REG_RESET_IN) begin
			dl2_q <= cpo_pkg::DISCHARGE_LIMIT2_AND_STATUS_RST; // RULE14
			uvb_q <= cpo_pkg::UNDERVOLTAGE_DITHER_BUS_PROTECT_RST; // RULE14
			st2_q <= cpo_pkg::SYSTEM_THRESHOLD2_ROLE_SWAP_RST; // RULE14
		end else if (wr_stb) begin
			unique case (wr_addr)
				cpo_pkg::DISCHARGE_LIMIT2_AND_STATUS_ADDR:
					dl2_q <= merge(dl2_q, wr_data, cpo_pkg::DL2_WR_MASK); // RULE17
				cpo_pkg::UNDERVOLTAGE_DITHER_BUS_PROTECT_ADDR:
					uvb_q <= merge(uvb_q, wr_data, cpo_pkg::UVB_WR_MASK); // RULE17
				cpo_pkg::SYSTEM_THRESHOLD2_ROLE_SWAP_ADDR:
					st2_q <= merge(st2_q, wr_data, cpo_pkg::ST2_WR_MASK);
				default: begin
				end
			endcase
		end
	end

	// a trip in the same cycle as the clearing read survives
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			dl2_tripped_q <= 1'b0;
		end else if (dl2_trip) begin
			dl2_tripped_q <= 1'b1; // RULE4
		end else if (rd_clr || REG_RESET_IN) begin
			dl2_tripped_q <= 1'b0; // RULE4
		end
	end

	function automatic logic [7:0] read_reg(input logic [7:0] a);
		unique case (a)
			cpo_pkg::DISCHARGE_LIMIT2_AND_STATUS_ADDR:
				read_reg = {dl2_q[7:2], dl2_tripped_q, PASS_THROUGH_OPERATION_IN}; // RULE5
			cpo_pkg::UNDERVOLTAGE_DITHER_BUS_PROTECT_ADDR:
				read_reg = {uvb_q[7:1], BUS_PROTECT_TRIPPED_IN}; // RULE10
			cpo_pkg::SYSTEM_THRESHOLD2_ROLE_SWAP_ADDR:
				read_reg = st2_q;
			default:
				read_reg = 8'h00;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// limit-two comparison and filter
	// ----------------------------------------------------------------
	// ratio in quarters of limit one: 125% is 5/4 up to 400% as 16/4
	function automatic logic [4:0] ratio_quarters(input logic [2:0] code);
		unique case (code)
			3'h0: ratio_quarters = 5'h05;
			3'h1: ratio_quarters = 5'h06;
			3'h2: ratio_quarters = 5'h07;
			3'h3: ratio_quarters = 5'h08;
			3'h4: ratio_quarters = 5'h0a;
			3'h5: ratio_quarters = 5'h0c;
			3'h6: ratio_quarters = 5'h0e;
			default: ratio_quarters = 5'h10;
		endcase
	endfunction

	cpo_filter_if fif ();
	logic [CUR_W+4:0] cur_x4;
	logic [CUR_W+4:0] lim_x;
	assign cur_x4 = (CUR_W+5)'({DISCHARGE_CURRENT_IN, 2'b00});
	assign lim_x = (CUR_W+5)'(DISCHARGE_LIMIT1_LEVEL_IN) *
		(CUR_W+5)'(ratio_quarters(dl2_q[cpo_pkg::RATIO_LSB +: 3])); // RULE2
	assign fif.tick = tick;
	assign fif.over = cur_x4 > lim_x; // RULE16
	assign fif.filter_time = dl2_q[cpo_pkg::FILTER_TIME_LSB +: 2]; // RULE1
	assign dl2_trip = fif.tripped;

	cpo_filter #(
		.T00_US(cpo_pkg::FILTER_00_US),
		.T01_US(cpo_pkg::FILTER_01_US),
		.T10_US(T10_US),
		.T11_US(T11_US)
	) u_filter (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.f(fif)
	);

	// ----------------------------------------------------------------
	// undervoltage retry
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		UV_RUN = 4'b0001,
		UV_OFF = 4'b0010,
		UV_LATCH = 4'b0100
	} cpo_uv_e;

	cpo_uv_e uv_q;
	logic [2:0] fail_q;
	logic [26:0] win_q;
	logic [19:0] off_q;
	logic win_run;
	logic retry_dis;
	assign win_run = (win_q != 27'h0000000);
	assign retry_dis = uvb_q[cpo_pkg::UV_RETRY_DIS_BIT];

	// the window opens on the first failure; seven inside it latch off
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			uv_q <= UV_RUN;
			fail_q <= 3'h0;
			win_q <= 27'h0000000;
			off_q <= 20'h00000;
		end else if (REG_RESET_IN) begin
			uv_q <= UV_RUN;
			fail_q <= 3'h0;
			win_q <= 27'h0000000;
			off_q <= 20'h00000;
		end else begin
			if (tick && win_run) begin
				win_q <= win_q - 27'h0000001;
			end
			if (tick && win_q == 27'h0000001) begin
				fail_q <= 3'h0;
			end
			unique case (uv_q)
				UV_RUN: begin
					if (UNDERVOLTAGE_TRIP_IN) begin
						if (retry_dis) begin
							uv_q <= UV_LATCH; // RULE8
						end else if (fail_q == cpo_pkg::RETRY_LIMIT - 3'h1 && win_run) begin
							uv_q <= UV_LATCH; // RULE7
						end else begin
							uv_q <= UV_OFF; // RULE7
							off_q <= 20'(RETRY_OFF_US);
							fail_q <= win_run ? fail_q + 3'h1 : 3'h1;
							if (!win_run) begin
								win_q <= 27'(RETRY_WINDOW_US);
							end
						end
					end
				end
				UV_OFF: begin
					if (tick) begin
						off_q <= off_q - 20'h00001;
						if (off_q == 20'h00001) begin
							uv_q <= UV_RUN;
						end
					end
				end
				UV_LATCH: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// serial bus target
	// ----------------------------------------------------------------
	typedef enum logic [7:0] {
		SB_IDLE = 8'b00000001,
		SB_ADDR = 8'b00000010,
		SB_ACK = 8'b00000100,
		SB_PTR = 8'b00001000,
		SB_WDAT = 8'b00010000,
		SB_RDAT = 8'b00100000,
		SB_HACK = 8'b01000000
	} cpo_sb_e;

	cpo_sb_e sb_q;
	cpo_sb_e after_ack_q;
	logic scl_q;
	logic sda_q;
	logic [7:0] sh_q;
	logic [3:0] bit_q;
	logic [7:0] ptr_q;
	logic drive_q;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic rd_load;
	assign scl_rise = SCL_IN && !scl_q;
	assign scl_fall = !SCL_IN && scl_q;
	assign start_c = SCL_IN && scl_q && sda_q && !SDA_IN;
	assign stop_c = SCL_IN && scl_q && !sda_q && SDA_IN;
	assign rd_load = scl_fall && ((sb_q == SB_ACK && after_ack_q == SB_RDAT) ||
		(sb_q == SB_HACK && !sh_q[0]));
	assign rd_clr = rd_load && ptr_q == cpo_pkg::DISCHARGE_LIMIT2_AND_STATUS_ADDR; // RULE4
	assign wr_stb = scl_fall && sb_q == SB_WDAT && bit_q == 4'h8;
	assign wr_addr = ptr_q;
	assign wr_data = sh_q;

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= SCL_IN;
			sda_q <= SDA_IN;
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			sb_q <= SB_IDLE;
			after_ack_q <= SB_IDLE;
			sh_q <= 8'h00;
			bit_q <= 4'h0;
			ptr_q <= 8'h00;
			drive_q <= 1'b0;
		end else if (start_c) begin
			sb_q <= SB_ADDR;
			bit_q <= 4'h0;
			drive_q <= 1'b0;
		end else if (stop_c) begin
			sb_q <= SB_IDLE;
			drive_q <= 1'b0;
		end else if (scl_rise) begin
			if (sb_q == SB_HACK) begin
				sh_q[0] <= SDA_IN;
			end else if (sb_q == SB_ADDR || sb_q == SB_PTR || sb_q == SB_WDAT) begin
				sh_q <= {sh_q[6:0], SDA_IN};
				bit_q <= bit_q + 4'h1;
			end else if (sb_q == SB_RDAT) begin
				bit_q <= bit_q + 4'h1;
			end
		end else if (scl_fall) begin
			unique case (sb_q)
				SB_ADDR: begin
					if (bit_q == 4'h8) begin
						bit_q <= 4'h0;
						if (sh_q[7:1] == cpo_pkg::TARGET_ADDR) begin
							sb_q <= SB_ACK;
							after_ack_q <= sh_q[0] ? SB_RDAT : SB_PTR;
							drive_q <= 1'b1;
						end else begin
							sb_q <= SB_IDLE;
						end
					end
				end
				SB_PTR, SB_WDAT: begin
					if (bit_q == 4'h8) begin
						bit_q <= 4'h0;
						sb_q <= SB_ACK;
						after_ack_q <= SB_WDAT;
						drive_q <= 1'b1;
						ptr_q <= (sb_q == SB_PTR) ? sh_q : ptr_q + 8'h01;
					end
				end
				SB_ACK, SB_HACK: begin
					if (rd_load) begin
						sb_q <= SB_RDAT;
						sh_q <= read_reg(ptr_q);
						drive_q <= ~|(read_reg(ptr_q) & 8'h80);
						ptr_q <= ptr_q + 8'h01;
					end else begin
						sb_q <= (sb_q == SB_ACK) ? after_ack_q : SB_IDLE;
						drive_q <= 1'b0;
					end
				end
				SB_RDAT: begin
					if (bit_q == 4'h8) begin
						bit_q <= 4'h0;
						sb_q <= SB_HACK;
						drive_q <= 1'b0;
					end else begin
						drive_q <= !sh_q[3'(7 - bit_q)];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign SDA_OUT = 1'b0;
	assign SDA_OE_N_OUT = !drive_q;
	assign DITHER_OUT = uvb_q[cpo_pkg::DITHER_LSB +: 2]; // RULE9
	assign SYSTEM_UNDERVOLTAGE_LEVEL_OUT = uvb_q[cpo_pkg::UV_LEVEL_LSB +: 3]; // RULE6
	assign BUS_PROTECT_ALERT_ENABLE_OUT = uvb_q[cpo_pkg::BUS_ALERT_BIT]; // RULE10
	assign DISCHARGE_LIMIT2_ALERT_OUT = dl2_q[cpo_pkg::DL2_ALERT_BIT] && dl2_tripped_q; // RULE3
	assign SYSTEM_TRIGGER_LEVEL_TWO_OUT = st2_q[cpo_pkg::LEVEL_TWO_LSB +: 6]; // RULE11
	assign LEVEL_TWO_TRACKS_LEVEL_ONE_OUT = st2_q[cpo_pkg::TRACKS_BIT]; // RULE12
	assign ROLE_SWAP_ENABLE_OUT = st2_q[cpo_pkg::ROLE_SWAP_BIT]; // RULE13
	assign CONVERTER_ENABLE_OUT = (uv_q == UV_RUN); // RULE7
	assign CONVERTER_LATCHED_OFF_OUT = (uv_q == UV_LATCH); // RULE7
endmodule

// [sim/cpo_regs_monitor.sv]
`timescale 1ns/1ps
module cpo_regs_monitor #(
	parameter int RETRY_OFF_US = 10
) (
	input wire logic CLK_IN, // clock
	input wire logic RST_IN, // reset
	input wire logic REG_RESET_IN, // register reset
	input wire logic SCL_IN, // serial clock
	input wire logic UNDERVOLTAGE_TRIP_IN, // uv event
	input wire logic [1:0] DITHER_OUT, // dither
	input wire logic [2:0] SYSTEM_UNDERVOLTAGE_LEVEL_OUT, // uv level
	input wire logic BUS_PROTECT_ALERT_ENABLE_OUT, // bus alert
	input wire logic [5:0] SYSTEM_TRIGGER_LEVEL_TWO_OUT, // level two
	input wire logic LEVEL_TWO_TRACKS_LEVEL_ONE_OUT, // tracking
	input wire logic ROLE_SWAP_ENABLE_OUT, // role swap
	input wire logic CONVERTER_ENABLE_OUT, // run
	input wire logic CONVERTER_LATCHED_OFF_OUT // latched
);
	// slack of about one us tick either side, since the tick phase is free
	localparam int OFF_MIN = RETRY_OFF_US * 50 - 55;
	localparam int OFF_MAX = RETRY_OFF_US * 50 + 55;
	logic [19:0] off_cnt_q;
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			off_cnt_q <= 20'h0;
		end else begin
			off_cnt_q <= CONVERTER_ENABLE_OUT ? 20'h0 : off_cnt_q + 20'h1;
		end
	end
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);
	sequence s_run_trip;
		UNDERVOLTAGE_TRIP_IN && CONVERTER_ENABLE_OUT && !REG_RESET_IN;
	endsequence
	sequence s_retry_end;
		$rose(CONVERTER_ENABLE_OUT) && !$past(CONVERTER_LATCHED_OFF_OUT) && !$past(REG_RESET_IN);
	endsequence
	property p_trip_stops;
		s_run_trip |-> ##[1:2] !CONVERTER_ENABLE_OUT;
	endproperty
	property p_off_time;
		s_retry_end |-> off_cnt_q >= OFF_MIN && off_cnt_q <= OFF_MAX;
	endproperty
	property p_latch_off;
		CONVERTER_LATCHED_OFF_OUT |-> !CONVERTER_ENABLE_OUT;
	endproperty
	property p_latch_holds;
		CONVERTER_LATCHED_OFF_OUT && !REG_RESET_IN |=> CONVERTER_LATCHED_OFF_OUT;
	endproperty
	property p_latch_cause;
		$rose(CONVERTER_LATCHED_OFF_OUT) |->
			$past(UNDERVOLTAGE_TRIP_IN) || $past(UNDERVOLTAGE_TRIP_IN, 2);
	endproperty
	property p_reg_reset_cfg;
		REG_RESET_IN |=> {SYSTEM_UNDERVOLTAGE_LEVEL_OUT, DITHER_OUT, BUS_PROTECT_ALERT_ENABLE_OUT,
			SYSTEM_TRIGGER_LEVEL_TWO_OUT, LEVEL_TWO_TRACKS_LEVEL_ONE_OUT, ROLE_SWAP_ENABLE_OUT} == 14'h0024;
	endproperty
	property p_reg_reset_conv;
		REG_RESET_IN |=> CONVERTER_ENABLE_OUT && !CONVERTER_LATCHED_OFF_OUT;
	endproperty
	property p_cfg_by_bus;
		$changed({DITHER_OUT, SYSTEM_UNDERVOLTAGE_LEVEL_OUT, SYSTEM_TRIGGER_LEVEL_TWO_OUT})
			&& !$past(REG_RESET_IN) |-> !SCL_IN;
	endproperty
	a_trip_stops: assert property (p_trip_stops) else $error("converter ran on after trip");
	a_off_time: assert property (p_off_time) else $error("retry off time wrong");
	a_latch_off: assert property (p_latch_off) else $error("latched but enabled");
	a_latch_holds: assert property (p_latch_holds) else $error("latch left");
	a_latch_cause: assert property (p_latch_cause) else $error("latch without trip");
	a_reg_reset_cfg: assert property (p_reg_reset_cfg) else $error("cfg not reset");
	a_reg_reset_conv: assert property (p_reg_reset_conv) else $error("retry not reset");
	a_cfg_by_bus: assert property (p_cfg_by_bus) else $error("cfg moved");
endmodule
bind cpo_regs cpo_regs_monitor #(.RETRY_OFF_US(RETRY_OFF_US)) u_mon (.CLK_IN(CLK_IN),
	.RST_IN(RST_IN), .REG_RESET_IN(REG_RESET_IN), .SCL_IN(SCL_IN),
	.UNDERVOLTAGE_TRIP_IN(UNDERVOLTAGE_TRIP_IN),
	.DITHER_OUT(DITHER_OUT), .SYSTEM_UNDERVOLTAGE_LEVEL_OUT(SYSTEM_UNDERVOLTAGE_LEVEL_OUT),
	.BUS_PROTECT_ALERT_ENABLE_OUT(BUS_PROTECT_ALERT_ENABLE_OUT),
	.SYSTEM_TRIGGER_LEVEL_TWO_OUT(SYSTEM_TRIGGER_LEVEL_TWO_OUT),
	.LEVEL_TWO_TRACKS_LEVEL_ONE_OUT(LEVEL_TWO_TRACKS_LEVEL_ONE_OUT),
	.ROLE_SWAP_ENABLE_OUT(ROLE_SWAP_ENABLE_OUT), .CONVERTER_ENABLE_OUT(CONVERTER_ENABLE_OUT),
	.CONVERTER_LATCHED_OFF_OUT(CONVERTER_LATCHED_OFF_OUT));

// [sim/cpo_host.sv]
`timescale 1ns/1ps
module cpo_host (
	input wire logic clk_in, // bench clock
	input wire logic sda_in, // resolved data wire
	output logic scl_out, // serial clock
	output logic sda_oe_n_out // low while pulling data low
);
	initial begin
		scl_out = 1'b1;
		sda_oe_n_out = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// data moves only mid-low; sampled at the end of the high phase
	task automatic slot(input logic a, output logic r);
		scl_out <= 1'b0;
		wt(2);
		sda_oe_n_out <= a;
		wt(2);
		scl_out <= 1'b1;
		wt(4);
		r = sda_in;
	endtask
	task automatic cond(input logic a);
		logic r;
		slot(a, r);
		sda_oe_n_out <= ~a;
		wt(4);
	endtask
	task automatic xb(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic nak);
		for (int i = 7; i >= 0; i--) begin
			slot(d[i], q[i]);
		end
		slot(ak, nak);
	endtask
	task automatic wr(input logic bad, input logic [7:0] p, input logic [7:0] d, output logic nak);
		logic [7:0] q;
		logic a0;
		logic a1;
		logic a2;
		wt(1);
		cond(1'b1);
		xb({cpo_pkg::TARGET_ADDR ^ {6'h00, bad}, 1'b0}, 1'b1, q, a0);
		xb(p, 1'b1, q, a1);
		xb(d, 1'b1, q, a2);
		cond(1'b0);
		nak = a0 | a1 | a2;
	endtask
	// a nack on the data byte ends the read after one byte
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic [7:0] q;
		logic a;
		wt(1);
		cond(1'b1);
		xb({cpo_pkg::TARGET_ADDR, 1'b0}, 1'b1, q, a);
		xb(p, 1'b1, q, a);
		cond(1'b1);
		xb({cpo_pkg::TARGET_ADDR, 1'b1}, 1'b1, q, a);
		xb(8'hff, 1'b1, d, a);
		cond(1'b0);
	endtask
endmodule

// [sim/charger_protection_option_regs_tb.sv]
`timescale 1ns/1ps
module charger_protection_option_regs_tb;
	localparam logic [23:0] ROWS [8] = '{24'h3cfffc, 24'h3c0300, 24'h3dfffe, 24'h3d3030,
		24'h3d5a5a, 24'h3ea5a5, 24'h3e0202, 24'h3f1200};
	localparam logic [15:0] DEF [3] = '{16'h3c48, 16'h3d00, 16'h3e24};
	localparam int Q [8] = '{5, 6, 7, 8, 10, 12, 14, 16};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic reg_rst = 1'b0;
	logic pt = 1'b0;
	logic bus_trip = 1'b0;
	logic uv = 1'b0;
	logic [11:0] cur = 12'h000;
	logic scl;
	logic host_oe_n;
	logic dut_oe_n;
	logic [1:0] dither;
	logic [2:0] uvl;
	logic [5:0] lvl2;
	logic bus_al, al, trk, frs, en, lat, nak;
	logic [7:0] rv;
	int num_errors = 0;
	int n_tests = 0;
	// open-drain wire with pull-up
	wire sda = host_oe_n & dut_oe_n;
	always #10 clk = ~clk;
	cpo_host host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_n_out(host_oe_n));
	cpo_regs #(.T10_US(20), .T11_US(30), .RETRY_WINDOW_US(2000), .RETRY_OFF_US(10)) DUT (
		.CLK_IN(clk), .RST_IN(rst), .REG_RESET_IN(reg_rst), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(), .SDA_OE_N_OUT(dut_oe_n), .DISCHARGE_CURRENT_IN(cur),
		.DISCHARGE_LIMIT1_LEVEL_IN(12'h064), .PASS_THROUGH_OPERATION_IN(pt),
		.BUS_PROTECT_TRIPPED_IN(bus_trip), .UNDERVOLTAGE_TRIP_IN(uv), .DITHER_OUT(dither),
		.SYSTEM_UNDERVOLTAGE_LEVEL_OUT(uvl), .BUS_PROTECT_ALERT_ENABLE_OUT(bus_al),
		.DISCHARGE_LIMIT2_ALERT_OUT(al), .SYSTEM_TRIGGER_LEVEL_TWO_OUT(lvl2),
		.LEVEL_TWO_TRACKS_LEVEL_ONE_OUT(trk), .ROLE_SWAP_ENABLE_OUT(frs),
		.CONVERTER_ENABLE_OUT(en), .CONVERTER_LATCHED_OFF_OUT(lat));
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk_def();
		for (int i = 0; i < 3; i++) begin
			host.rd(DEF[i][15:8], rv);
			check("default", rv, DEF[i][7:0]);
		end
	endtask
	task automatic pulse(input logic to_uv);
		wt(1);
		if (to_uv) begin
			uv <= 1'b1;
		end else begin
			reg_rst <= 1'b1;
		end
		wt(1);
		uv <= 1'b0;
		reg_rst <= 1'b0;
		wt(2);
	endtask
	initial begin
		#(20 * 80000);
		num_errors++;
		give_verdict();
	end
	initial begin
		wt(6);
		rst <= 1'b0;
		wt(2);
		for (int i = 0; i < 8; i++) begin
			host.wr(1'b0, ROWS[i][23:16], ROWS[i][15:8], nak);
			host.rd(ROWS[i][23:16], rv);
			check("ack", 8'(nak), 8'h00);
			check("readback", rv, ROWS[i][7:0]);
			if (ROWS[i][23:16] == 8'h3d) begin
				check("uv dither", {uvl, dither, bus_al}, {ROWS[i][15:11], ROWS[i][9]});
			end
			if (ROWS[i][23:16] == 8'h3e) begin
				check("level two", {lvl2, trk, frs}, ROWS[i][15:8]);
			end
		end
		// second reset in mid-run
		wt(1);
		rst <= 1'b1;
		wt(6);
		rst <= 1'b0;
		wt(2);
		chk_def();
		check("level two out", 8'(lvl2), 8'h09);
		host.wr(1'b1, 8'h3e, 8'h00, nak);
		check("wrong target", 8'(nak), 8'h01);
		host.rd(8'h3e, rv);
		check("untouched", rv, 8'h24);
		wt(1);
		pt <= 1'b1;
		bus_trip <= 1'b1;
		host.rd(8'h3c, rv);
		check("pass through", rv, 8'h49);
		host.rd(8'h3d, rv);
		check("bus tripped", rv, 8'h01);
		pt <= 1'b0;
		bus_trip <= 1'b0;
		// each ratio: level exactly at the limit never trips, one above does
		for (int r = 0; r < 8; r++) begin
			host.wr(1'b0, {2'b10, 3'(r), 3'b100}, 8'h3c, nak);
			host.wr(1'b0, 8'h3c, {2'b10, 3'(r), 3'b100}, nak);
			cur <= 12'(25 * Q[r]);
			wt(1200);
			check("no trip", 8'(al), 8'h00);
			cur <= 12'(25 * Q[r] + 1);
			wt(900);
			check("early", 8'(al), 8'h00);
			wt(300);
			check("trip", 8'(al), 8'h01);
			cur <= 12'h000;
			host.wr(1'b0, 8'h3c, {2'b10, 3'(r), 3'b000}, nak);
			check("alert off", 8'(al), 8'h00);
			host.rd(8'h3c, rv);
			check("trip bit", rv, {2'b10, 3'(r), 3'b010});
		end
		host.rd(8'h3c, rv);
		check("trip cleared", {rv[1], al}, 8'h00);
		host.wr(1'b0, 8'h3e, 8'hff, nak);
		pulse(1'b0);
		chk_def();
		for (int i = 1; i <= 7; i++) begin
			pulse(1'b1);
			check("off", 8'(en), 8'h00);
			wt(600);
			check("latched", {en, lat}, (i == 7) ? 8'h01 : 8'h02);
		end
		pulse(1'b0);
		check("unlatched", {en, lat}, 8'h02);
		host.wr(1'b0, 8'h3d, 8'h04, nak);
		pulse(1'b1);
		check("no retry", {en, lat}, 8'h01);
		pulse(1'b0);
		give_verdict();
	end
endmodule
